// [logic/cbs_pkg.sv]
// Purpose: Shared constants and types for the circular output buffer with function swap.
// Assumes: Byte addresses on the local register port, 32-bit data words.
// Notes: Buffer words are 17 bits: sample in [15:0], end-of-frame mark in bit 16.
package cbs_pkg;

  // Local register byte offsets
  localparam logic [7:0] CBS_OFF_BOARD_CTRL = 8'h00;
  localparam logic [7:0] CBS_OFF_ASSY_CFG = 8'h10;
  localparam logic [7:0] CBS_OFF_BUF_OPS = 8'h14;
  localparam logic [7:0] CBS_OFF_BUF_DATA = 8'h18;
  localparam logic [7:0] CBS_OFF_DMA_MODE = 8'h80;
  localparam logic [7:0] CBS_OFF_DMA_HADDR = 8'h84;
  localparam logic [7:0] CBS_OFF_DMA_LADDR = 8'h88;
  localparam logic [7:0] CBS_OFF_DMA_COUNT = 8'h8C;
  localparam logic [7:0] CBS_OFF_DMA_DESC = 8'h90;
  localparam logic [7:0] CBS_OFF_DMA_CMD = 8'hA8;

  // Fixed local address of the output data buffer, as a DMA target
  localparam logic [31:0] CBS_BUF_LOCAL_ADDR = 32'h0000_0018;

  // Buffer word layout
  localparam int CBS_WORD_W = 17;
  localparam int CBS_EOF_BIT = 16;

  // Board control fields
  localparam int CBS_BCR_ISEL_LSB = 8;
  localparam int CBS_BCR_ISEL_W = 3;
  localparam int CBS_BCR_IPEND = 11;
  localparam logic [2:0] CBS_ISEL_BUF_OPEN = 3'h6;
  localparam logic [2:0] CBS_ISEL_SWAP_DONE = 3'h7;

  // Buffer operations fields
  localparam int CBS_BOPS_CIRC = 0;
  localparam int CBS_BOPS_CLK_EN = 1;
  localparam int CBS_BOPS_CLEAR = 2;
  localparam int CBS_BOPS_LOAD_REQ = 3;
  localparam int CBS_BOPS_LOAD_RDY = 4;
  localparam int CBS_BOPS_EMPTY = 5;
  localparam int CBS_BOPS_REFUSED = 6;
  localparam int CBS_BOPS_FIFO_FULL = 7;

  // DMA mode fields
  localparam logic [1:0] CBS_MODE_WIDTH32 = 2'h3;
  localparam int CBS_MODE_DONE_IEN = 10;
  localparam int CBS_MODE_LADDR_CONST = 11;
  localparam int CBS_MODE_DEMAND = 12;
  localparam int CBS_MODE_FAST_TERM = 15;
  localparam int CBS_DESC_DIR = 3;

  // DMA command/status fields
  localparam int CBS_CMD_EN = 0;
  localparam int CBS_CMD_START = 1;
  localparam int CBS_CMD_CLR_INT = 3;
  localparam int CBS_CMD_DONE = 4;

  // Reset values and figures
  localparam logic [31:0] CBS_DMA_REG_RST = 32'h0000_0000;
  localparam logic [11:0] CBS_FW_DEMAND_MIN = 12'h007;
  localparam logic [31:0] CBS_BYTES_PER_BEAT = 32'h0000_0004;

  typedef enum logic [1:0] {
    CBS_LINEAR,
    CBS_CLOSED,
    CBS_OPEN
  } cbs_state_t;

endpackage

// [logic/cbs_fifo.sv]
// Purpose: Staging FIFO between the bus-side writers and the output buffer.
// Assumes: DEPTH is a power of two.
// Notes: in_ready is a flop so a source can use it without a combinational path.
`timescale 1ns/1ps
module cbs_fifo #(
  parameter int W = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic not_full_q;
  logic push;
  logic pop;

  assign push = in_valid & not_full_q;
  assign pop = out_valid & out_ready;
  assign in_ready = not_full_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];

  // Occupancy after this cycle's push and pop
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Pointers and count; full flag registered from the next count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      not_full_q <= 1'b1;
    end else if (ce) begin
      if (clr) begin
        wp_q <= '0;
        rp_q <= '0;
        cnt_q <= '0;
        not_full_q <= 1'b1;
      end else begin
        if (push) wp_q <= wp_q + 1'b1;
        if (pop) rp_q <= rp_q + 1'b1;
        cnt_q <= cnt_d;
        not_full_q <= (cnt_d != (AW+1)'(DEPTH));
      end
    end
  end

  // Storage has no reset; only the pointers matter
  always_ff @(posedge clk) begin
    if (ce && push && !clr) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule // cbs_fifo

// [logic/cbs_core.sv]
// Purpose: Output buffer sequencing with gapless function swap and DMA loading.
// Assumes: One clock; sample clock arrives on a pin; bridge logic shares clk.
// Notes: Registers sit on a local strobe port at their byte offsets.
//
// Summary of operation
// - Closed circular buffer refuses bus writes into the data buffer.
// - With swap requested, buffer opens at the old set's end-of-frame mark.
// - Buffer open raises an interrupt request when that source is selected.
// - Open buffer stops recirculating and discards old values once sent.
// - Outputs keep coming from old values until they have drained.
// - Last old value out recloses the buffer; new set follows gaplessly.
// - Reclosing clears the swap request bit and the buffer open flag.
// - Selectable swap-complete interrupt fires when the buffer recloses.
// - DMA into the buffer in block or demand mode, board as master.
// - DMA uses the fixed non-incrementing local buffer address 18h.
// - Descriptor value zero selects PCI-to-local transfer direction.
// - Block mode needs 32-bit width in the DMA mode register.
// - Mode bit 12 high selects demand mode, rest as block mode.
// - Demand mode requires slow termination, mode bit 15 low.
// - Demand mode exists only from firmware revision 7 onward.
// - Circular mode replays the loaded set until a swap drains and discards it.
`timescale 1ns/1ps
module cbs_core
  import cbs_pkg::*;
#(
  parameter int BUF_DEPTH = 64,
  parameter int FIFO_DEPTH = 8,
  parameter logic [11:0] FW_REV = 12'h009
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic bus_master_en,
  output logic dma_req,
  output logic [31:0] dma_addr,
  input wire logic dma_rvalid,
  input wire logic [31:0] dma_rdata,
  output logic dma_rready,
  input wire logic sample_clk_pin,
  output logic [15:0] dac_data,
  output logic dac_eof,
  output logic dac_update,
  output logic irq
);
  localparam int AW = $clog2(BUF_DEPTH);

  // Wrapping pointer step for the replay ring
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(BUF_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Address match for a write strobe
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
    wr_hit = reg_wr && (a == off);
  endfunction

  cbs_state_t state_q;
  logic [CBS_WORD_W-1:0] ring_q [BUF_DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [AW:0] old_left_q;
  logic [2:0] samp_sync_q;
  logic circ_q;
  logic clk_en_q;
  logic load_req_q;
  logic load_rdy_q;
  logic refused_q;
  logic [2:0] isel_q;
  logic ipend_q;
  logic [31:0] mode_q;
  logic [31:0] haddr_q;
  logic [31:0] laddr_q;
  logic [31:0] bcnt_q;
  logic [31:0] desc_q;
  logic cmd_en_q;
  logic cmd_done_q;
  logic dma_busy_q;
  logic [CBS_WORD_W-1:0] head;
  logic [CBS_WORD_W-1:0] fifo_od;
  logic fifo_ov;
  logic fifo_or;
  logic fifo_ir;
  logic fifo_iv;
  logic samp_edge;
  logic clr;
  logic tick;
  logic repush;
  logic fill;
  logic open_evt;
  logic close_evt;
  logic pio_ok;
  logic dma_start;
  logic dma_cfg_ok;
  logic demand;
  logic beat;
  logic last;

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock pin: two-flop synchroniser, third flop only for the edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_sync_q <= '0;
    end else if (ce) begin
      samp_sync_q <= {samp_sync_q[1:0], sample_clk_pin};
    end
  end
  assign samp_edge = samp_sync_q[1] & ~samp_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Replay ring control terms
  assign clr = wr_hit(reg_addr, CBS_OFF_BUF_OPS) & reg_wdata[CBS_BOPS_CLEAR];
  assign head = ring_q[rp_q];
  assign tick = samp_edge & clk_en_q & (cnt_q != '0) & ~clr;
  // Closed replay puts every sent word back at the tail
  assign repush = tick & (state_q == CBS_CLOSED);
  // Ring fill only when no sample is taken and the buffer is not closed
  assign fifo_or = ~tick & ~clr & (state_q != CBS_CLOSED) & (cnt_q != (AW+1)'(BUF_DEPTH));
  assign fill = fifo_or & fifo_ov;
  assign open_evt = tick & (state_q == CBS_CLOSED) & load_req_q & head[CBS_EOF_BIT];
  assign close_evt = tick & (state_q == CBS_OPEN) & (old_left_q == (AW+1)'(1));

  // Buffer state: circular bit closes it, swap opens it, drain recloses it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= CBS_LINEAR;
    end else if (ce) begin
      case (state_q)
        CBS_LINEAR: if (circ_q && !clr) state_q <= CBS_CLOSED;
        CBS_CLOSED: begin
          if (!circ_q || clr) state_q <= CBS_LINEAR;
          else if (open_evt) state_q <= CBS_OPEN;
        end
        CBS_OPEN: begin
          if (!circ_q || clr) state_q <= CBS_LINEAR;
          else if (close_evt) state_q <= CBS_CLOSED;
        end
        default: state_q <= CBS_LINEAR;
      endcase
    end
  end

  // Ring pointers and count; the old set is one full frame deep when opened
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      old_left_q <= '0;
    end else if (ce) begin
      if (clr) begin
        wp_q <= '0;
        rp_q <= '0;
        cnt_q <= '0;
        old_left_q <= '0;
      end else begin
        if (tick) rp_q <= ptr_inc(rp_q);
        if (repush || fill) wp_q <= ptr_inc(wp_q);
        // Open buffer discards each sent word instead of recirculating it
        if (tick && !repush) cnt_q <= cnt_q - 1'b1;
        else if (fill) cnt_q <= cnt_q + 1'b1;
        if (open_evt) old_left_q <= cnt_q;
        else if (tick && state_q == CBS_OPEN) old_left_q <= old_left_q - 1'b1;
      end
    end
  end

  // Ring storage; a repushed word keeps its end-of-frame mark
  always_ff @(posedge clk) begin
    if (ce && !clr && (repush || fill)) begin
      ring_q[wp_q] <= repush ? head : fifo_od;
    end
  end

  // Outputs are driven only from the ring head, old values first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_data <= '0;
      dac_eof <= 1'b0;
      dac_update <= 1'b0;
    end else if (ce) begin
      dac_update <= tick;
      if (tick) begin
        dac_data <= head[15:0];
        dac_eof <= head[CBS_EOF_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer operations register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      circ_q <= 1'b0;
      clk_en_q <= 1'b0;
      load_req_q <= 1'b0;
      load_rdy_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (ce) begin
      if (wr_hit(reg_addr, CBS_OFF_BUF_OPS)) begin
        circ_q <= reg_wdata[CBS_BOPS_CIRC];
        clk_en_q <= reg_wdata[CBS_BOPS_CLK_EN];
      end
      // A software set wins over the automatic clear in the same cycle
      if (wr_hit(reg_addr, CBS_OFF_BUF_OPS) && !clr) load_req_q <= reg_wdata[CBS_BOPS_LOAD_REQ];
      else if (close_evt || clr) load_req_q <= 1'b0;
      if (open_evt) load_rdy_q <= 1'b1;
      else if (close_evt || clr) load_rdy_q <= 1'b0;
      // Dropped data writes are sticky; writing one clears unless a new drop lands
      if (wr_hit(reg_addr, CBS_OFF_BUF_DATA) && !pio_ok) refused_q <= 1'b1;
      else if (wr_hit(reg_addr, CBS_OFF_BUF_OPS) && reg_wdata[CBS_BOPS_REFUSED]) refused_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Board control: interrupt source select and pending flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      isel_q <= '0;
      ipend_q <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wr_hit(reg_addr, CBS_OFF_BOARD_CTRL)) begin
        isel_q <= reg_wdata[CBS_BCR_ISEL_LSB +: CBS_BCR_ISEL_W];
      end
      // Event set beats the host clear of the pending flag
      if ((open_evt && isel_q == CBS_ISEL_BUF_OPEN) ||
          (close_evt && isel_q == CBS_ISEL_SWAP_DONE)) begin
        ipend_q <= 1'b1;
      end else if (wr_hit(reg_addr, CBS_OFF_BOARD_CTRL)) begin
        ipend_q <= reg_wdata[CBS_BCR_IPEND];
      end
      irq <= ipend_q | (cmd_done_q & mode_q[CBS_MODE_DONE_IEN]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staging FIFO: DMA beats have priority, direct writes only when idle
  assign pio_ok = wr_hit(reg_addr, CBS_OFF_BUF_DATA) & (state_q != CBS_CLOSED)
                  & ~dma_busy_q & fifo_ir;
  assign beat = dma_busy_q & dma_rvalid & fifo_ir;
  assign fifo_iv = beat | pio_ok;

  cbs_fifo #(
    .W(CBS_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clr(clr),
    .in_valid(fifo_iv),
    .in_ready(fifo_ir),
    .in_data(dma_busy_q ? dma_rdata[CBS_WORD_W-1:0] : reg_wdata[CBS_WORD_W-1:0]),
    .out_valid(fifo_ov),
    .out_ready(fifo_or),
    .out_data(fifo_od)
  );

  // Ready is the FIFO's registered not-full flag; a closed ring stalls DMA
  assign dma_rready = fifo_ir;

  ////////////////////////////////////////////////////////////////////////////
  // DMA engine checks and handshake terms
  assign dma_cfg_ok = (mode_q[1:0] == CBS_MODE_WIDTH32)
                      & mode_q[CBS_MODE_LADDR_CONST] & (laddr_q == CBS_BUF_LOCAL_ADDR)
                      & ~desc_q[CBS_DESC_DIR]
                      & (bcnt_q != '0);
  // Start takes enable and start together, with bus mastering granted
  assign dma_start = wr_hit(reg_addr, CBS_OFF_DMA_CMD) & reg_wdata[CBS_CMD_EN]
                     & reg_wdata[CBS_CMD_START] & bus_master_en & ~dma_busy_q & dma_cfg_ok;
  // Older firmware or fast termination falls back to block mode
  assign demand = mode_q[CBS_MODE_DEMAND] & ~mode_q[CBS_MODE_FAST_TERM]
                  & (FW_REV >= CBS_FW_DEMAND_MIN);
  assign last = beat & (bcnt_q <= CBS_BYTES_PER_BEAT);

  // DMA configuration registers, frozen while a transfer runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= CBS_DMA_REG_RST;
      laddr_q <= CBS_DMA_REG_RST;
      desc_q <= CBS_DMA_REG_RST;
    end else if (ce && !dma_busy_q) begin
      if (wr_hit(reg_addr, CBS_OFF_DMA_MODE)) mode_q <= reg_wdata;
      if (wr_hit(reg_addr, CBS_OFF_DMA_LADDR)) laddr_q <= reg_wdata;
      if (wr_hit(reg_addr, CBS_OFF_DMA_DESC)) desc_q <= reg_wdata;
    end
  end

  // Source address and byte count advance per accepted beat
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      haddr_q <= CBS_DMA_REG_RST;
      bcnt_q <= CBS_DMA_REG_RST;
    end else if (ce) begin
      if (beat) begin
        haddr_q <= haddr_q + CBS_BYTES_PER_BEAT;
        bcnt_q <= last ? '0 : bcnt_q - CBS_BYTES_PER_BEAT;
      end else if (!dma_busy_q) begin
        if (wr_hit(reg_addr, CBS_OFF_DMA_HADDR)) haddr_q <= reg_wdata;
        if (wr_hit(reg_addr, CBS_OFF_DMA_COUNT)) bcnt_q <= reg_wdata;
      end
    end
  end

  // Command/status and the request line toward the bridge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_en_q <= 1'b0;
      cmd_done_q <= 1'b0;
      dma_busy_q <= 1'b0;
      dma_req <= 1'b0;
      dma_addr <= '0;
    end else if (ce) begin
      if (wr_hit(reg_addr, CBS_OFF_DMA_CMD)) cmd_en_q <= reg_wdata[CBS_CMD_EN];
      if (dma_start) dma_busy_q <= 1'b1;
      else if (last) dma_busy_q <= 1'b0;
      // Completion set wins over a host clear in the same cycle
      if (last) cmd_done_q <= 1'b1;
      else if (dma_start || (wr_hit(reg_addr, CBS_OFF_DMA_CMD) && reg_wdata[CBS_CMD_CLR_INT])) begin
        cmd_done_q <= 1'b0;
      end
      // Demand mode drops the request while the FIFO has no room
      dma_req <= (dma_start | (dma_busy_q & ~last)) & (~demand | fifo_ir);
      dma_addr <= beat ? haddr_q + CBS_BYTES_PER_BEAT : haddr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register readback, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= '0;
        case (reg_addr)
          CBS_OFF_BOARD_CTRL: begin
            reg_rdata[CBS_BCR_ISEL_LSB +: CBS_BCR_ISEL_W] <= isel_q;
            reg_rdata[CBS_BCR_IPEND] <= ipend_q;
          end
          CBS_OFF_ASSY_CFG: reg_rdata[11:0] <= FW_REV;
          CBS_OFF_BUF_OPS: begin
            reg_rdata[CBS_BOPS_CIRC] <= circ_q;
            reg_rdata[CBS_BOPS_CLK_EN] <= clk_en_q;
            reg_rdata[CBS_BOPS_LOAD_REQ] <= load_req_q;
            reg_rdata[CBS_BOPS_LOAD_RDY] <= load_rdy_q;
            reg_rdata[CBS_BOPS_EMPTY] <= (cnt_q == '0);
            reg_rdata[CBS_BOPS_REFUSED] <= refused_q;
            reg_rdata[CBS_BOPS_FIFO_FULL] <= ~fifo_ir;
          end
          CBS_OFF_DMA_MODE: reg_rdata <= mode_q;
          CBS_OFF_DMA_HADDR: reg_rdata <= haddr_q;
          CBS_OFF_DMA_LADDR: reg_rdata <= laddr_q;
          CBS_OFF_DMA_COUNT: reg_rdata <= bcnt_q;
          CBS_OFF_DMA_DESC: reg_rdata <= desc_q;
          CBS_OFF_DMA_CMD: begin
            reg_rdata[CBS_CMD_EN] <= cmd_en_q;
            reg_rdata[CBS_CMD_DONE] <= cmd_done_q;
          end
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule // cbs_core

// [tb/cbs_sva.sv]
// Purpose: Port-level checks of the output buffer core.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only the top module's ports; attached by bind.
`timescale 1ns/1ps
module cbs_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic bus_master_en,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic dma_rvalid,
  input wire logic dma_rready,
  input wire logic [15:0] dac_data,
  input wire logic dac_eof,
  input wire logic dac_update,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Register port answers exactly one cycle after the strobe
  rd_answer_a: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read strobe without answer");
  rd_quiet_a: assert property (ce && !reg_rd |=> !reg_rvalid)
    else $error("answer without read strobe");
  rdata_hold_a: assert property (ce && !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved between reads");
  unmapped_rd_a: assert property (ce && reg_rd && reg_addr == 8'h44 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  // One pulse per sample; a stuck strobe would double-play words
  dac_pulse_a: assert property (dac_update |=> !dac_update)
    else $error("sample strobe longer than one cycle");
  freeze_a: assert property (!ce |=> $stable(dac_data) && $stable(dma_addr) && $stable(irq))
    else $error("state moved with clock enable low");
  // A start needs bus mastering and the full start code
  no_master_a: assert property (ce && reg_wr && reg_addr == 8'hA8 && !bus_master_en &&
    !dma_req |=> !dma_req) else $error("transfer started without bus mastering");
  start_code_a: assert property (ce && reg_wr && reg_addr == 8'hA8 &&
    reg_wdata[1:0] != 2'b11 && !dma_req |=> !dma_req) else $error("start without code 3");
  beat_step_a: assert property (ce && dma_req && dma_rvalid && dma_rready |=>
    dma_addr == $past(dma_addr) + 32'h0000_0004) else $error("source address step wrong");
  cover property (dac_update && dac_eof);
  cover property ($rose(irq));
  cover property (dma_req && dma_rvalid && dma_rready);
endmodule // cbs_sva
bind cbs_core cbs_sva i_sva (.*);

// [tb/cbs_bridge_model.sv]
// Purpose: Bridge DMA source that hands beats to the core.
// Assumes: Beat data is derived from the source address.
// Notes: slow inserts a two-cycle gap before each beat.
`timescale 1ns/1ps
module cbs_bridge_model (
  input wire logic clk,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic dma_rready,
  input wire logic slow,
  input wire logic [31:0] eof_addr,
  output logic dma_rvalid,
  output logic [31:0] dma_rdata
);
  logic took_q;
  logic [1:0] gap_q;
  initial begin
    dma_rvalid = 1'b0;
    dma_rdata = 32'h0;
    took_q = 1'b0;
    gap_q = 2'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Remember a taken beat so the next offer uses the new address
  always @(posedge clk) begin
    took_q <= dma_rvalid && dma_rready && dma_req;
  end
  // Beats move host to board only; idle data toggles so stale values never match
  always @(negedge clk) begin
    if (!dma_req || took_q) begin
      dma_rvalid <= 1'b0;
      dma_rdata <= ~dma_rdata;
      gap_q <= slow ? 2'h2 : 2'h0;
    end else if (!dma_rvalid && gap_q != 2'h0) begin
      gap_q <= gap_q - 2'h1;
      dma_rdata <= ~dma_rdata;
    end else if (!dma_rvalid) begin
      dma_rvalid <= 1'b1;
      dma_rdata <= {15'h0, dma_addr == eof_addr, dma_addr[15:0]};
    end
  end
endmodule // cbs_bridge_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the output buffer core.
// Assumes: Inputs change on the falling edge.
// Notes: Samples are paced by the bench on the sample clock pin.
`timescale 1ns/1ps
module tb_top;
  import cbs_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, bme = 0, pin = 0, slow = 1;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, dma_addr, dma_rdata, rv;
  logic reg_rvalid, dma_req, dma_rvalid, dma_rready, dac_eof, dac_update, irq;
  logic [15:0] dac_data;
  logic [7:0] offs [7] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'hA8, 8'h44};
  int miscompares = 0, n_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  cbs_core #(.BUF_DEPTH(64), .FIFO_DEPTH(8), .FW_REV(12'h009)) i_dut (.clk(clk),
    .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .bus_master_en(bme), .dma_req(dma_req), .dma_addr(dma_addr), .dma_rvalid(dma_rvalid),
    .dma_rdata(dma_rdata), .dma_rready(dma_rready), .sample_clk_pin(pin),
    .dac_data(dac_data), .dac_eof(dac_eof), .dac_update(dac_update), .irq(irq));
  cbs_bridge_model i_br (.clk(clk), .dma_req(dma_req), .dma_addr(dma_addr),
    .dma_rready(dma_rready), .slow(slow), .eof_addr(32'h0000_C10C),
    .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A hung handshake ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One sample: raise the pin, wait for the strobe, compare mark and value
  task automatic chk_smp(input logic [16:0] exp);
    logic [16:0] got;
    got = 'x;
    @(negedge clk);
    pin = 1'b1;
    for (int i = 0; i < 12 && dac_update !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (dac_update === 1'b1) got = {dac_eof, dac_data};
    @(negedge clk);
    pin = 1'b0;
    repeat (2) @(negedge clk);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // Reset values, an unmapped hole and the firmware revision
    foreach (offs[i]) begin
      rd(offs[i], rv);
      chk_reg(rv, CBS_DMA_REG_RST);
    end
    rd(8'h10, rv);
    chk_reg({20'h0, rv[11:0]}, 32'h0000_0009);
    $display("T1 reset done");
    // Closed ring replays the whole set and refuses new data
    for (int i = 0; i < 4; i++) wr(8'h18, {15'h0, i == 3, 16'hA000 + 16'(i)});
    wr(8'h14, 32'h0000_0003);
    for (int i = 0; i < 8; i++) chk_smp({i % 4 == 3, 16'hA000 + 16'(i % 4)});
    wr(8'h18, 32'h0001_BEEF);
    rd(8'h14, rv);
    chk_reg({31'h0, rv[CBS_BOPS_REFUSED]}, 32'h0000_0001);
    wr(8'h14, 32'h0000_0043);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    ce = 1'b1;
    $display("T2 circular done");
    // Swap: open at the mark, drain one old frame, reclose onto the new set
    wr(8'h00, 32'h0000_0600);
    wr(8'h14, 32'h0000_000B);
    for (int i = 0; i < 4; i++) chk_smp({i == 3, 16'hA000 + 16'(i)});
    rd(8'h14, rv);
    chk_reg({31'h0, rv[CBS_BOPS_LOAD_RDY]}, 32'h0000_0001);
    chk_reg({31'h0, irq}, 32'h0000_0001);
    wr(8'h00, 32'h0000_0700);
    // Interrupt line follows the pending flag one clock later
    @(negedge clk);
    chk_reg({31'h0, irq}, 32'h0);
    for (int i = 0; i < 3; i++) wr(8'h18, {15'h0, i == 2, 16'hB000 + 16'(i)});
    for (int i = 0; i < 4; i++) chk_smp({i == 3, 16'hA000 + 16'(i)});
    rd(8'h14, rv);
    chk_reg({30'h0, rv[4:3]}, 32'h0);
    chk_reg({31'h0, irq}, 32'h0000_0001);
    wr(8'h00, 32'h0);
    for (int i = 0; i < 6; i++) chk_smp({i % 3 == 2, 16'hB000 + 16'(i % 3)});
    $display("T3 swap done");
    // Block transfer: refused without mastering, then four beats
    wr(8'h14, 32'h0000_0004);
    wr(8'h80, 32'h0002_0D43);
    wr(8'h84, 32'h0000_C100);
    wr(8'h88, CBS_BUF_LOCAL_ADDR);
    wr(8'h8C, 32'h0000_0010);
    wr(8'h90, 32'h0);
    wr(8'hA8, 32'h0000_0001);
    wr(8'hA8, 32'h0000_0003);
    chk_reg({31'h0, dma_req}, 32'h0);
    bme = 1'b1;
    wr(8'hA8, 32'h0000_0001);
    wr(8'hA8, 32'h0000_0003);
    chk_reg({31'h0, dma_req}, 32'h0000_0001);
    for (int i = 0; i < 200 && dma_req !== 1'b0; i++) @(negedge clk);
    rd(8'hA8, rv);
    chk_reg({31'h0, rv[CBS_CMD_DONE]}, 32'h0000_0001);
    chk_reg({31'h0, irq}, 32'h0000_0001);
    wr(8'h14, 32'h0000_0002);
    for (int i = 0; i < 4; i++) chk_smp({i == 3, 16'hC100 + 16'(4 * i)});
    wr(8'hA8, 32'h0000_0008);
    @(negedge clk);
    chk_reg({31'h0, irq}, 32'h0);
    $display("T4 block done");
    // Demand transfer into a stalled ring: FIFO fills, request drops, then drains
    wr(8'h14, 32'h0000_0004);
    wr(8'h14, 32'h0000_0001);
    wr(8'h80, 32'h0002_1943);
    wr(8'h84, 32'h0000_C200);
    wr(8'h8C, 32'h0000_0028);
    slow = 1'b0;
    wr(8'hA8, 32'h0000_0001);
    wr(8'hA8, 32'h0000_0003);
    repeat (40) @(negedge clk);
    chk_reg({30'h0, dma_req, dma_rready}, 32'h0);
    rd(8'h14, rv);
    chk_reg({31'h0, rv[CBS_BOPS_FIFO_FULL]}, 32'h0000_0001);
    wr(8'h14, 32'h0);
    rv = 32'h0;
    for (int i = 0; i < 300 && rv[CBS_CMD_DONE] !== 1'b1; i++) rd(8'hA8, rv);
    chk_reg({31'h0, rv[CBS_CMD_DONE]}, 32'h0000_0001);
    wr(8'h14, 32'h0000_0004);
    rd(8'h14, rv);
    chk_reg({31'h0, rv[CBS_BOPS_EMPTY]}, 32'h0000_0001);
    $display("T5 demand done");
    test_done();
  end
endmodule // tb_top
